// ===== verilog/pst_target.sv
// Two-wire bus target: address decode, register index, reads and writes.
// Assumes scl_i and sda_i are raw pins; reg_rdata_i is driven on clk_i.
// Notes on behaviour
// - Target only; decode 7-bit address plus read/write bit.
// - Any start condition with no power-state clear in the same cycle abandons the current transfer and restarts decoding.
// - No inactivity timeout; stalled transfer waits for start, stop or clear.
// - Power-state clear forces the bus machine to idle, dropping transfers.
// - Answer one configured address; write byte lsb low, read byte lsb high.
// - Works at any bus clock from static up to the bench's 800 ns bit (1250 kHz).
// - Spikes up to 50 ns on both lines are never seen as edges.
// - Data line only pulled low or released; clock line input only.
`default_nettype none
module pst_target #(
  parameter int unsigned FILT_CYC = pst_pkg::PST_SPIKE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [6:0] tgt_addr_i,
  input wire logic pwr_clear_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  input wire logic [7:0] reg_rdata_i,
  output logic busy_o
);
  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;
  pst_pkg::pst_state_t st_r;
  pst_pkg::pst_state_t st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic drv_r;
  logic drv_nxt;
  logic rd_r;
  logic rd_nxt;
  logic first_r;
  logic first_nxt;
  logic wr_nxt;
  logic wr_bump_r;

  pst_deglitch #(.FILT_CYC(FILT_CYC)) u_scl_filt (
    .clk_i(clk_i), .rst_i(rst_i), .line_i(scl_i), .line_o(scl_f)
  );
  pst_deglitch #(.FILT_CYC(FILT_CYC)) u_sda_filt (
    .clk_i(clk_i), .rst_i(rst_i), .line_i(sda_i), .line_o(sda_f)
  );

  // Bus events on filtered lines
  wire scl_rise = scl_f && !scl_d_r;
  wire scl_fall = !scl_f && scl_d_r;
  wire start_det = scl_f && scl_d_r && sda_d_r && !sda_f;
  wire stop_det = scl_f && scl_d_r && !sda_d_r && sda_f;
  wire addr_hit = (sh_r[7:1] == tgt_addr_i);
  wire in_byte = (cnt_r < pst_pkg::PST_CNT_ACK);
  wire at_ack = (cnt_r == pst_pkg::PST_CNT_ACK);
  wire at_done = (cnt_r == pst_pkg::PST_CNT_DONE);
  wire rx_state = (st_r == pst_pkg::PST_ST_ADDR) || (st_r == pst_pkg::PST_ST_WRITE);
  wire [2:0] tx_bit = 3'(7 - cnt_r);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    idx_nxt = idx_r;
    drv_nxt = drv_r;
    rd_nxt = rd_r;
    first_nxt = first_r;
    wr_nxt = 1'b0;
    if (pwr_clear_i) begin
      st_nxt = pst_pkg::PST_ST_IDLE;
      drv_nxt = 1'b0;
    end else if (start_det) begin
      st_nxt = pst_pkg::PST_ST_ADDR;
      cnt_nxt = 4'h0;
      drv_nxt = 1'b0;
      first_nxt = 1'b1;
    end else if (stop_det) begin
      st_nxt = pst_pkg::PST_ST_IDLE;
      drv_nxt = 1'b0;
    end else if (st_r != pst_pkg::PST_ST_IDLE) begin
      // Waits on bus edges only; nothing here counts time
      if (scl_rise) begin
        if (in_byte) begin
          sh_nxt = {sh_r[6:0], sda_f};
          cnt_nxt = cnt_r + 4'h1;
        end else if (at_ack) begin
          cnt_nxt = pst_pkg::PST_CNT_DONE;
          if (st_r == pst_pkg::PST_ST_READ && sda_f) begin
            st_nxt = pst_pkg::PST_ST_IDLE; // Controller ended the read
          end
        end
      end else if (scl_fall) begin
        if (at_ack && rx_state) begin
          drv_nxt = 1'b1;
          if (st_r == pst_pkg::PST_ST_ADDR) begin
            rd_nxt = sh_r[0];
            if (!addr_hit) begin
              st_nxt = pst_pkg::PST_ST_IDLE;
              drv_nxt = 1'b0;
            end
          end else if (first_r) begin
            idx_nxt = sh_r;
            first_nxt = 1'b0;
          end else begin
            wr_nxt = 1'b1;
          end
        end else if (at_ack) begin
          drv_nxt = 1'b0; // Release for controller ack
          idx_nxt = idx_r + 8'h01;
        end else if (at_done) begin
          cnt_nxt = 4'h0;
          drv_nxt = 1'b0;
          if ((st_r == pst_pkg::PST_ST_ADDR && rd_r) || st_r == pst_pkg::PST_ST_READ) begin
            st_nxt = pst_pkg::PST_ST_READ;
            tx_nxt = reg_rdata_i;
            drv_nxt = !reg_rdata_i[7];
          end else if (st_r == pst_pkg::PST_ST_ADDR) begin
            st_nxt = pst_pkg::PST_ST_WRITE;
          end
        end else if (st_r == pst_pkg::PST_ST_READ && in_byte) begin
          drv_nxt = !tx_r[tx_bit];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_d_r <= pst_pkg::PST_IDLE_LVL;
      sda_d_r <= pst_pkg::PST_IDLE_LVL;
      st_r <= pst_pkg::PST_ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      idx_r <= 8'h00;
      drv_r <= 1'b0;
      rd_r <= 1'b0;
      first_r <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_wdata_o <= 8'h00;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      idx_r <= wr_bump_r ? idx_r + 8'h01 : idx_nxt;
      drv_r <= drv_nxt;
      rd_r <= rd_nxt;
      first_r <= first_nxt;
      reg_wr_o <= wr_nxt;
      reg_wdata_o <= wr_nxt ? sh_r : reg_wdata_o;
    end
  end

  // Index advances the cycle after a write strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_bump_r <= 1'b0;
    end else begin
      wr_bump_r <= wr_nxt;
    end
  end
  assign reg_addr_o = idx_r + {7'h00, wr_bump_r && !reg_wr_o};
  assign sda_o = 1'b0;
  assign sda_oe_o = drv_r;
  assign busy_o = (st_r != pst_pkg::PST_ST_IDLE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_restart: assert property (start_det && !pwr_clear_i
    |=> st_r == pst_pkg::PST_ST_ADDR && cnt_r == 4'h0 && !sda_oe_o)
    else $error("start did not restart decoding");
  a_clear_idle: assert property (pwr_clear_i
    |=> st_r == pst_pkg::PST_ST_IDLE && !sda_oe_o)
    else $error("power clear did not idle the machine");
  a_addr_ack: assert property (scl_fall && st_r == pst_pkg::PST_ST_ADDR && at_ack
    && addr_hit && !pwr_clear_i && !start_det && !stop_det |=> sda_oe_o[*1] ##1 1)
    else $error("matching address not acknowledged");
  a_addr_miss: assert property (scl_fall && st_r == pst_pkg::PST_ST_ADDR && at_ack
    && !addr_hit && !pwr_clear_i |=> st_r == pst_pkg::PST_ST_IDLE && !sda_oe_o)
    else $error("foreign address not ignored");
  a_no_timeout: assert property (st_r != pst_pkg::PST_ST_IDLE && !pwr_clear_i
    && !scl_rise && !scl_fall && !start_det && !stop_det |=> st_r == $past(st_r))
    else $error("state changed with no bus event");
  a_write_index: assert property (reg_wr_o
    |=> !reg_wr_o && reg_addr_o == $past(reg_addr_o) + 8'h01)
    else $error("register index did not advance after write");
  a_only_pull_low: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_bit_range: assert property (cnt_r <= pst_pkg::PST_CNT_DONE)
    else $error("bit counter out of range");
  a_read_drive: assert property (scl_fall && st_r == pst_pkg::PST_ST_READ && in_byte
    && cnt_r != 4'h0 && !pwr_clear_i && !start_det && !stop_det
    |=> sda_oe_o == !tx_r[$past(tx_bit)])
    else $error("read bit not driven from data");

  c_write_strobe: cover property (reg_wr_o);
  c_read_phase: cover property (st_r == pst_pkg::PST_ST_ADDR ##[1:300] st_r == pst_pkg::PST_ST_READ);
  c_restart: cover property (st_r == pst_pkg::PST_ST_WRITE && start_det);
endmodule
`default_nettype wire

// ===== verilog/pst_pkg.sv
// Package of constants for the serial target port.
// Assumes a 10 MHz block clock; shared by the target and its input filters.
`default_nettype none
package pst_pkg;
  // Default target address
  localparam logic [6:0] PST_DEF_ADDR = 7'h5A;
  // Clock period and spike width to reject
  localparam int unsigned PST_CLK_NS = 100;
  localparam int unsigned PST_SPIKE_NS = 50;
  // Samples a level must hold before it is taken; one more than a spike can cover
  localparam int unsigned PST_SPIKE_CYC = PST_SPIKE_NS / PST_CLK_NS + 2;
  // Bus level of released lines
  localparam logic PST_IDLE_LVL = 1'b1;
  // Bit count at which the ninth (acknowledge) clock is reached
  localparam logic [3:0] PST_CNT_ACK = 4'h8;
  localparam logic [3:0] PST_CNT_DONE = 4'h9;
  typedef enum logic [1:0] {
    PST_ST_IDLE = 2'b00,
    PST_ST_ADDR = 2'b01,
    PST_ST_WRITE = 2'b10,
    PST_ST_READ = 2'b11
  } pst_state_t;
endpackage
`default_nettype wire

// ===== verilog/pst_deglitch.sv
// Two-stage synchroniser followed by a spike filter for one bus line.
// Assumes the line is asynchronous to clk_i and idles high.
`default_nettype none
module pst_deglitch #(
  parameter int unsigned FILT_CYC = pst_pkg::PST_SPIKE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  output logic line_o
);
  logic s1_r;
  logic s2_r;
  logic out_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire differ = (s2_r != out_r);
  wire settle = differ && (cnt_r >= 4'(FILT_CYC - 1));

  assign cnt_nxt = (differ && !settle) ? cnt_r + 4'h1 : 4'h0;
  assign line_o = out_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= pst_pkg::PST_IDLE_LVL;
      s2_r <= pst_pkg::PST_IDLE_LVL;
      out_r <= pst_pkg::PST_IDLE_LVL;
      cnt_r <= 4'h0;
    end else begin
      s1_r <= line_i;
      s2_r <= s1_r;
      cnt_r <= cnt_nxt;
      if (settle) begin
        out_r <= s2_r;
      end
    end
  end

  a_filter_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (out_r != $past(out_r)) |-> ($past(s2_r) == out_r))
    else $error("filtered line changed without a settled sample");
endmodule
`default_nettype wire

// ===== dv/pst_ctrl_model.sv
// Bus controller model: start, stop, byte write and byte read.
// Assumes a pull-up resolves the data line outside this module.
`default_nettype none
module pst_ctrl_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One 800 ns bit: long low phase leaves room for the target's filtered drive
  task automatic bit_x(input logic b, output logic s);
    #100 sda_low_o = ~b;
    #500 scl_o = 1'b1;
    #100 s = sda_i;
    #100 scl_o = 1'b0;
  endtask
  // Waits out a target drive before raising the clock
  task automatic start();
    sda_low_o = 1'b0;
    #600 scl_o = 1'b1;
    #200 sda_low_o = 1'b1;
    #200 scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #600 scl_o = 1'b1;
    #200 sda_low_o = 1'b0;
    #600;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ak = ~s;
  endtask
  task automatic rbyte(input logic ak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~ak, s);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the serial target port.
// Assumes the controller model and a pulled-up data line.
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, pwr_clear_i = 0, gl_scl = 0, gl_sda = 0;
  logic [6:0] tgt_addr_i = pst_pkg::PST_DEF_ADDR;
  logic [7:0] mem [256];
  logic [7:0] reg_addr_o, reg_wdata_o, rd;
  logic reg_wr_o, busy_o, sda_o, sda_oe_o, scl_m, sda_low, ack;
  logic [15:0] exp_q [$];
  logic [15:0] w;
  int fail_count = 0, num_checks = 0, cyc = 0;
  wire logic sda = ~(sda_low | sda_oe_o);
  always #50 clk_i = ~clk_i;
  pst_ctrl_model m (.scl_o(scl_m), .sda_low_o(sda_low), .sda_i(sda));
  pst_target DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_m ^ gl_scl),
    .sda_i(sda ^ gl_sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .tgt_addr_i(tgt_addr_i),
    .pwr_clear_i(pwr_clear_i), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .reg_wr_o(reg_wr_o), .reg_rdata_i(mem[reg_addr_o]), .busy_o(busy_o));
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b, input logic e);
    m.wbyte(b, ack);
    `CHK("ack", e, ack)
  endtask
  // Each write strobe is matched against the oldest expected write
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      close_out();
    end
    if (reg_wr_o === 1'b1) begin
      w = exp_q.pop_front();
      `CHK("write", w, {reg_addr_o, reg_wdata_o})
    end
  end
  initial begin
    logic [7:0] ix, d0, d1;
    logic [6:0] alt [5] = '{7'h25, 7'h27, 7'h67, 7'h6B, 7'h5A};
    void'($urandom(1877));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (20) @(posedge clk_i);
    #10 rst_i = 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    #30 gl_sda = 1'b1;
    #40 gl_sda = 1'b0;
    repeat (8) @(posedge clk_i);
    #10;
    `CHK("busy", 1'b0, busy_o)
    ix = 8'($urandom);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    exp_q.push_back({ix, d0});
    exp_q.push_back({ix + 8'h01, d1});
    m.start();
    tx(8'hB4, 1'b1);
    tx(ix, 1'b1);
    fork
      tx(d0, 1'b1);
      begin
        @(negedge clk_i);
        #30 gl_scl = 1'b1;
        #40 gl_scl = 1'b0;
      end
    join
    tx(d1, 1'b1);
    m.stop();
    `CHK("busy", 1'b0, busy_o)
    m.start();
    tx(8'hB4, 1'b1);
    tx(ix, 1'b1);
    m.start();
    tx(8'hB5, 1'b1);
    m.rbyte(1'b1, rd);
    `CHK("read", mem[ix], rd)
    d0 = rd;
    m.rbyte(1'b0, rd);
    `CHK("read", mem[ix + 8'h01], rd)
    m.stop();
    // Read-modify-write keeps the untouched bits
    exp_q.push_back({ix, mem[ix] ^ 8'h01});
    m.start();
    tx(8'hB4, 1'b1);
    tx(ix, 1'b1);
    tx(d0 ^ 8'h01, 1'b1);
    m.stop();
    // Abandon a half byte by a fresh start
    d0 = 8'($urandom);
    m.start();
    tx(8'hB4, 1'b1);
    tx(ix, 1'b1);
    for (int i = 0; i < 4; i++) m.bit_x(1'b0, rd[0]);
    exp_q.push_back({ix, d0});
    m.start();
    tx(8'hB4, 1'b1);
    tx(ix, 1'b1);
    tx(d0, 1'b1);
    m.stop();
    foreach (alt[i]) begin
      @(posedge clk_i);
      #10 tgt_addr_i = alt[i];
      m.start();
      tx({alt[i] ^ 7'h01, 1'b0}, 1'b0);
      `CHK("busy", 1'b0, busy_o)
      m.stop();
      m.start();
      tx({alt[i], 1'b0}, 1'b1);
      m.stop();
    end
    m.start();
    tx(8'hB4, 1'b1);
    tx(ix, 1'b1);
    #50000;
    `CHK("busy", 1'b1, busy_o)
    @(posedge clk_i);
    #10 pwr_clear_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #10 pwr_clear_i = 1'b0;
    `CHK("busy", 1'b0, busy_o)
    tx(d1, 1'b0);
    m.stop();
    `CHK("queue", 0, exp_q.size())
    close_out();
  end
endmodule
`default_nettype wire
